// *** verilog/ris_sequencer.sv ***
// reset and interrupt sequencer with its axi4-lite register slave
`timescale 1ns/1ps
module ris_sequencer #(
  parameter int POR_CYCLES = ris_pkg::POR_TCYC,
  parameter int CYC_CLKS = ris_pkg::CYC_CLKS,
  parameter bit EDGE_ONLY = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic irq_pin_n,
  input wire logic reset_pin_n,
  input wire logic osc_ready,
  // core events
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic stop_enter,
  input wire logic wait_enter,
  input wire logic timer_event,
  // core registers
  input wire logic [10:0] cpu_pc,
  input wire logic [7:0] cpu_x,
  input wire logic [7:0] cpu_a,
  // core control
  output logic core_reset,
  output logic seq_busy,
  output logic vec_fetch,
  output logic [10:0] vec_addr,
  output logic resume,
  output logic [10:0] resume_pc,
  output logic [7:0] resume_x,
  output logic [7:0] resume_a,
  output logic [4:0] condition_flags,
  output logic stop_latch,
  output logic wait_latch,
  // ports
  output logic [7:0] dir_a,
  output logic [7:0] dir_b,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  // stack ram
  output logic [6:0] stack_addr,
  output logic stack_we,
  output logic stack_re,
  output logic [7:0] stack_wdata,
  input wire logic [7:0] stack_rdata,
  // axi4-lite
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ris_pkg::ris_state_e state;
  logic [2:0] step;
  logic [6:0] sp;
  logic [4:0] cc;
  logic irq_s, rst_pin_s, osc_s, osc_q, irq_q;
  logic [15:0] div_cnt, por_cnt;
  logic cyc_en, por_busy, in_reset, in_reset_q, rst_release;
  logic ext_latch, tmr_flag, tmr_mask, ext_req, timer_req;
  logic idle_ok, boundary, take_swi, take_ext, take_tmr, take_rti, take_push;
  logic [39:0] push_sr, pull_sr;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data, wmask, wr_cur, wr_word;
  logic [3:0] w_strb;
  logic wr_go, wr_hit;
  logic [32:0] wr_rd, ar_rd;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ris_sync3 #(.INIT(1'b1)) u_irq (.clk(clk), .rst_n(rst_n), .din(irq_pin_n), .dout(irq_s));
  ris_sync3 #(.INIT(1'b1)) u_rst (.clk(clk), .rst_n(rst_n), .din(reset_pin_n), .dout(rst_pin_s));
  ris_sync3 #(.INIT(1'b0)) u_osc (.clk(clk), .rst_n(rst_n), .din(osc_ready), .dout(osc_s));

  ////////////////////////////////////////////////////////////////////////////
  // instruction-cycle enable and power-on delay
  always_ff @(posedge clk) begin
    if (!rst_n || cyc_en) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign cyc_en = (div_cnt == 16'(CYC_CLKS - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_busy <= 1'b1;
      por_cnt <= 16'h0000;
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_s;
      // only a rising supply restarts the delay; a drop does nothing
      if (osc_s && !osc_q) begin
        por_busy <= 1'b1;
        por_cnt <= 16'h0000;
      end else if (por_busy && osc_s && cyc_en) begin
        por_cnt <= por_cnt + 16'h0001;
        if (por_cnt == 16'(POR_CYCLES - 1)) begin
          por_busy <= 1'b0;
        end
      end
    end
  end

  // pin low at end of the delay keeps reset asserted
  assign in_reset = por_busy || !rst_pin_s;
  assign core_reset = in_reset;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= in_reset;
    end
  end
  assign rst_release = in_reset_q && !in_reset;

  ////////////////////////////////////////////////////////////////////////////
  // request latches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b1;
      ext_latch <= 1'b0;
    end else begin
      irq_q <= irq_s;
      if (in_reset) begin
        ext_latch <= 1'b0;
      end else if (irq_q && !irq_s) begin
        ext_latch <= 1'b1;
      end else if (take_ext) begin
        ext_latch <= 1'b0;
      end
    end
  end
  // level term re-arms service while wired-or line stays low
  assign ext_req = ext_latch || (!EDGE_ONLY && !irq_s);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_flag <= 1'b0;
      tmr_mask <= 1'b1;
    end else if (in_reset) begin
      tmr_flag <= 1'b0;
      tmr_mask <= 1'b1;
    end else begin
      // event wins over a software clear in the same cycle
      if (timer_event) begin
        tmr_flag <= 1'b1;
      end else if (wr_go && aw_addr == ris_pkg::ADDR_TIMER && !wr_word[ris_pkg::TMR_FLAG_BIT]) begin
        tmr_flag <= 1'b0;
      end
      if (wr_go && aw_addr == ris_pkg::ADDR_TIMER) begin
        tmr_mask <= wr_word[ris_pkg::TMR_MASK_BIT];
      end
    end
  end
  // masked requests simply stay latched here
  assign timer_req = tmr_flag && !tmr_mask;

  ////////////////////////////////////////////////////////////////////////////
  // service decision
  assign idle_ok = (state == ris_pkg::ST_IDLE) && !in_reset && !rst_release;
  assign boundary = idle_ok && instr_done && !swi_exec;
  assign take_swi = idle_ok && swi_exec;
  assign take_ext = boundary && !cc[ris_pkg::CC_I] && ext_req;
  assign take_tmr = boundary && !cc[ris_pkg::CC_I] && !ext_req && timer_req;
  assign take_rti = idle_ok && rti_exec && !swi_exec;
  assign take_push = take_swi || take_ext || take_tmr;

  always_ff @(posedge clk) begin
    if (!rst_n || in_reset) begin
      state <= ris_pkg::ST_IDLE;
      step <= 3'h0;
      vec_addr <= ris_pkg::VEC_RESET;
    end else begin
      case (state)
        ris_pkg::ST_IDLE: begin
          step <= 3'h0;
          if (rst_release) begin
            state <= ris_pkg::ST_VECTOR;
          end else if (take_swi) begin
            state <= ris_pkg::ST_PUSH;
            vec_addr <= ris_pkg::VEC_SWI;
          end else if (take_ext) begin
            state <= ris_pkg::ST_PUSH;
            vec_addr <= ris_pkg::VEC_EXT;
          end else if (take_tmr) begin
            state <= ris_pkg::ST_PUSH;
            vec_addr <= ris_pkg::VEC_TIMER;
          end else if (take_rti) begin
            state <= ris_pkg::ST_PULL_RD;
          end
        end
        ris_pkg::ST_PUSH: begin
          step <= step + 3'h1;
          if (step == ris_pkg::STACK_LAST) begin
            state <= ris_pkg::ST_VECTOR;
          end
        end
        ris_pkg::ST_PULL_RD: state <= ris_pkg::ST_PULL_CAP;
        ris_pkg::ST_PULL_CAP: begin
          step <= step + 3'h1;
          if (step == ris_pkg::STACK_LAST) begin
            state <= ris_pkg::ST_RESUME;
          end else begin
            state <= ris_pkg::ST_PULL_RD;
          end
        end
        default: state <= ris_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer and frame registers
  always_ff @(posedge clk) begin
    if (!rst_n || in_reset) begin
      sp <= ris_pkg::SP_RESET;
    end else if (state == ris_pkg::ST_PUSH) begin
      // upper bits fixed, so the stack never leaves its 32-byte window
      sp <= {ris_pkg::SP_HI, 5'(sp[4:0] - 5'h01)};
    end else if (take_rti || (state == ris_pkg::ST_PULL_CAP && step != ris_pkg::STACK_LAST)) begin
      sp <= {ris_pkg::SP_HI, 5'(sp[4:0] + 5'h01)};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      push_sr <= '0;
    end else if (take_push) begin
      push_sr <= {3'h0, cc, cpu_a, cpu_x, 8'(cpu_pc >> ris_pkg::BYTE_W), cpu_pc[7:0]};
    end else if (state == ris_pkg::ST_PUSH) begin
      push_sr <= {8'h00, push_sr[39:8]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pull_sr <= '0;
    end else if (state == ris_pkg::ST_PULL_CAP) begin
      // flags come off first and end in the top byte
      pull_sr <= {pull_sr[31:0], stack_rdata};
    end
  end

  assign stack_addr = sp;
  assign stack_we = (state == ris_pkg::ST_PUSH);
  assign stack_re = (state == ris_pkg::ST_PULL_RD);
  assign stack_wdata = push_sr[7:0];
  assign vec_fetch = (state == ris_pkg::ST_VECTOR);
  assign resume = (state == ris_pkg::ST_RESUME);
  assign resume_pc = pull_sr[ris_pkg::PC_W-1:0];
  assign resume_x = pull_sr[ris_pkg::B_X*ris_pkg::BYTE_W +: ris_pkg::BYTE_W];
  assign resume_a = pull_sr[ris_pkg::B_A*ris_pkg::BYTE_W +: ris_pkg::BYTE_W];
  assign seq_busy = (state != ris_pkg::ST_IDLE);
  assign condition_flags = cc;

  ////////////////////////////////////////////////////////////////////////////
  // flags, latches and port registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cc <= ris_pkg::CC_RESET;
    end else if (in_reset) begin
      cc[ris_pkg::CC_I] <= 1'b1;
    end else if (state == ris_pkg::ST_PUSH && step == ris_pkg::STACK_LAST) begin
      cc[ris_pkg::CC_I] <= 1'b1;
    end else if (state == ris_pkg::ST_RESUME) begin
      cc <= pull_sr[ris_pkg::B_CC*ris_pkg::BYTE_W +: ris_pkg::CC_W];
    end else if (wr_go && aw_addr == ris_pkg::ADDR_FLAGS) begin
      cc <= wr_word[ris_pkg::CC_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || in_reset) begin
      stop_latch <= 1'b0;
      wait_latch <= 1'b0;
    end else begin
      if (stop_enter) begin
        stop_latch <= 1'b1;
      end else if (take_ext || take_tmr) begin
        stop_latch <= 1'b0;
      end
      if (wait_enter) begin
        wait_latch <= 1'b1;
      end else if (take_ext || take_tmr) begin
        wait_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || in_reset) begin
      dir_a <= 8'h00;
      dir_b <= 8'h00;
    end else if (wr_go && aw_addr == ris_pkg::ADDR_DIR) begin
      dir_a <= wr_word[7:0];
      dir_b <= wr_word[15:8];
    end
  end

  // output data survives device reset; only the system reset clears it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
    end else if (wr_go && aw_addr == ris_pkg::ADDR_PORT) begin
      port_a_out <= wr_word[7:0];
      port_b_out <= wr_word[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a == ris_pkg::ADDR_FLAGS) begin
      r[ris_pkg::CC_W-1:0] = cc;
    end else if (a == ris_pkg::ADDR_TIMER) begin
      r[ris_pkg::TMR_FLAG_BIT] = tmr_flag;
      r[ris_pkg::TMR_MASK_BIT] = tmr_mask;
    end else if (a == ris_pkg::ADDR_DIR) begin
      r[15:0] = {dir_b, dir_a};
    end else if (a == ris_pkg::ADDR_PORT) begin
      r[15:0] = {port_b_out, port_a_out};
    end else if (a == ris_pkg::ADDR_STATUS) begin
      r[12:0] = {seq_busy, wait_latch, stop_latch, ext_latch, in_reset, 1'b0, sp};
    end else begin
      r = 33'h0_0000_0000;
    end
    return r;
  endfunction : reg_read

  // a process, so register changes seen inside the function re-evaluate it
  always_comb begin
    wr_rd = reg_read(aw_addr);
    ar_rd = reg_read(s_araddr);
  end
  assign wr_cur = wr_rd[31:0];
  assign wr_hit = wr_rd[32];
  assign wr_go = aw_hold && w_hold && !s_bvalid && wr_hit;

  always_comb begin
    wmask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb[i]}};
    end
    // unstrobed lanes keep their present value
    wr_word = (wr_cur & ~wmask) | (w_data & wmask);
  end

  assign s_awready = !aw_hold && !s_bvalid;
  assign s_wready = !w_hold && !s_bvalid;
  assign s_arready = !s_rvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= ris_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (aw_hold && w_hold && !s_bvalid) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? ris_pkg::RESP_OKAY : ris_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= ris_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= ar_rd[31:0];
      s_rresp <= ar_rd[32] ? ris_pkg::RESP_OKAY : ris_pkg::RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence push_burst;
    stack_we [*5] ##1 vec_fetch;
  endsequence
  chk_reset_effects: assert property (in_reset |=> cc[ris_pkg::CC_I] && dir_a == 8'h00 && dir_b == 8'h00)
    else $error("reset did not set mask or clear directions");
  chk_reset_timer: assert property (in_reset |=> !tmr_flag && tmr_mask && sp == ris_pkg::SP_RESET)
    else $error("reset did not set timer bits or stack pointer");
  chk_reset_vector: assert property (rst_release |=> vec_fetch && vec_addr == ris_pkg::VEC_RESET)
    else $error("reset vector not fetched after release");
  chk_ext_first: assert property (take_ext && timer_req |=> state == ris_pkg::ST_PUSH && vec_addr == ris_pkg::VEC_EXT)
    else $error("timer served before external request");
  chk_mask_blocks: assert property (idle_ok && cc[ris_pkg::CC_I] && !swi_exec && !rti_exec |=> state == ris_pkg::ST_IDLE)
    else $error("masked request started a service");
  chk_no_midinst: assert property (idle_ok && !instr_done && !swi_exec && !rti_exec |=> !stack_we)
    else $error("service started inside an instruction");
  chk_push_order: assert property (take_push |=> push_burst)
    else $error("stacking burst or vector fetch out of step");
  chk_swi_unmasked: assert property (take_swi |=> vec_addr == ris_pkg::VEC_SWI && stack_we)
    else $error("software trap not serviced");
  chk_return_time: assert property (take_rti |=> ##10 resume)
    else $error("return did not resume after five pulls");
  chk_stack_window: assert property (sp[6:5] == ris_pkg::SP_HI)
    else $error("stack pointer left its window");
  chk_edge_latch: assert property (irq_q && !irq_s && !in_reset |=> ext_latch || stack_we)
    else $error("falling edge not latched");
endmodule : ris_sequencer

// *** verilog/ris_pkg.sv ***
// constants, register map and sequencer states of the reset and interrupt sequencer
// Summary of operation
// - external request sensitivity fixed at build: level plus falling edge, or edge only.
// - hardware requests wait for the running instruction to finish and mask clear.
// - at each instruction boundary pending unmasked interrupts start service, else continue.
// - mask flag blocks external and timer requests; they stay latched until cleared.
// - two reset sources: external low pin and power-on on rising supply only.
// - reset aborts the instruction at once; interrupts wait for its end.
// - power-on holds reset 1920 instruction cycles from first oscillator activity.
// - pin still low when power-on delay ends keeps reset until pin release.
// - any reset clears timer request flag and sets timer mask flag.
// - any reset clears every port direction bit, making pins inputs.
// - reset loads stack pointer with 7F; push decrements, pull increments it.
// - on reset the start address is fetched from vector pair 7FE and 7FF.
// - reset sets the mask flag, clears stop, wait and external request latches.
// - reset leaves every other register, port output data included, unchanged.
// - entry pushes processor registers and sets mask; return pulls them and resumes.
// - external request is served before timer request at the same boundary.
// - external taken with mask clear and line low or edge latched; vector 7FA/7FB.
// - level option: line still low after return gives a new external request.
// - software trap runs whatever the mask flag; vector 7FC and 7FD.
// - stack operations use no more than 32 bytes of RAM.
package ris_pkg;
  // timing
  localparam int CLK_NS = 4;
  localparam int TCYC_NS = 1000;
  localparam int CYC_CLKS = TCYC_NS / CLK_NS;
  localparam int POR_TCYC = 1920;
  // bus
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_TIMER = 8'h04;
  localparam logic [7:0] ADDR_DIR = 8'h08;
  localparam logic [7:0] ADDR_PORT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // condition flags: h i n z c
  localparam int CC_W = 5;
  localparam int CC_I = 3;
  localparam logic [4:0] CC_RESET = 5'h08;
  // timer control fields
  localparam int TMR_FLAG_BIT = 7;
  localparam int TMR_MASK_BIT = 6;
  // status fields
  localparam int ST_RST_BIT = 8;
  // vectors
  localparam int PC_W = 11;
  localparam logic [10:0] VEC_RESET = 11'h7fe;
  localparam logic [10:0] VEC_SWI = 11'h7fc;
  localparam logic [10:0] VEC_EXT = 11'h7fa;
  localparam logic [10:0] VEC_TIMER = 11'h7f8;
  // stack: 32-byte window at 60..7f
  localparam int SP_W = 7;
  localparam int SP_LOW_W = 5;
  localparam logic [1:0] SP_HI = 2'h3;
  localparam logic [6:0] SP_RESET = 7'h7f;
  // stacked frame, byte index = push order
  localparam int BYTE_W = 8;
  localparam int FRAME_BYTES = 5;
  localparam int FRAME_W = FRAME_BYTES * BYTE_W;
  localparam int B_X = 2;
  localparam int B_A = 3;
  localparam int B_CC = 4;
  localparam logic [2:0] STACK_LAST = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_VECTOR, ST_PULL_RD, ST_PULL_CAP, ST_RESUME
  } ris_state_e;
endpackage : ris_pkg

// *** verilog/ris_sync3.sv ***
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module ris_sync3 #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and result
  input wire logic din,
  output logic dout
);
  logic [2:0] sh;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh <= {3{INIT}};
      dout <= INIT;
    end else begin
      sh <= {sh[1:0], din};
      // a change counts only once stages two and three agree
      if (sh[1] == sh[2]) begin
        dout <= sh[2];
      end
    end
  end
endmodule : ris_sync3

// *** verification/ris_far_side.sv ***
// far side model: external request sources and reset circuitry
`timescale 1ns/1ps
module ris_far_side #(
  parameter int RST_MIN = 3
) (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic irq_req,
  input wire logic rst_req,
  input wire logic osc_on,
  // pins
  output logic irq_pin_n,
  output logic reset_pin_n,
  output logic osc_ready
);
  int low_cnt = 0;
  initial begin
    irq_pin_n = 1'h1;
    reset_pin_n = 1'h0;
    osc_ready = 1'h0;
  end
  // released request line floats high through the pull-up
  always @(posedge clk) begin
    irq_pin_n <= !irq_req;
    if (rst_req) low_cnt <= 0;
    else if (low_cnt < RST_MIN) low_cnt <= low_cnt + 1;
    // a short bench request is stretched, never cut below the minimum
    reset_pin_n <= !rst_req && low_cnt >= RST_MIN;
    osc_ready <= osc_on;
  end
endmodule : ris_far_side

// *** verification/reset_interrupt_sequencer_tb.sv ***
// self-checking bench for the reset and interrupt sequencer
`timescale 1ns/1ps
module reset_interrupt_sequencer_tb;
  logic clk = 1'h0, rst_n = 1'h0, irq_req = 1'h0, rst_req = 1'h1, osc_on = 1'h0;
  logic timer_event = 1'h0, stop_enter = 1'h0, wait_enter = 1'h0;
  logic [2:0] ev = 3'h0;
  logic instr_done, swi_exec, rti_exec, irq_pin_n, reset_pin_n, osc_ready;
  logic [10:0] cpu_pc = 11'h5a3;
  logic [7:0] cpu_x = 8'h3c, cpu_a = 8'hc5;
  logic core_reset, seq_busy, vec_fetch, resume, stop_latch, wait_latch, stack_we, stack_re;
  logic [10:0] vec_addr, resume_pc, vec_addr_e;
  logic [7:0] resume_x, resume_a, dir_a, dir_b, port_a_out, port_b_out, stack_wdata, stack_rdata;
  logic [4:0] condition_flags;
  logic [6:0] stack_addr;
  logic [7:0] mem [128];
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rs;
  int checks = 0, mismatches = 0, vf_cnt = 0;
  assign {rti_exec, swi_exec, instr_done} = ev;
  always #2 clk = ~clk;
  ris_far_side FAR (.clk, .irq_req, .rst_req, .osc_on, .irq_pin_n, .reset_pin_n, .osc_ready);
  ris_sequencer #(.POR_CYCLES(4), .CYC_CLKS(2)) DUT (.clk, .rst_n, .irq_pin_n, .reset_pin_n,
    .osc_ready, .instr_done, .swi_exec, .rti_exec, .stop_enter, .wait_enter, .timer_event,
    .cpu_pc, .cpu_x, .cpu_a, .core_reset, .seq_busy, .vec_fetch, .vec_addr, .resume,
    .resume_pc, .resume_x, .resume_a, .condition_flags, .stop_latch, .wait_latch, .dir_a,
    .dir_b, .port_a_out, .port_b_out, .stack_addr, .stack_we, .stack_re, .stack_wdata,
    .stack_rdata, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready);
  // edge-only twin on the same stimulus; it must not re-serve a held-low line
  ris_sequencer #(.POR_CYCLES(4), .CYC_CLKS(2), .EDGE_ONLY(1'b1)) DUT_EDGE (.clk, .rst_n,
    .irq_pin_n, .reset_pin_n, .osc_ready, .instr_done, .swi_exec, .rti_exec, .stop_enter,
    .wait_enter, .timer_event, .cpu_pc, .cpu_x, .cpu_a, .core_reset(), .seq_busy(),
    .vec_fetch(), .vec_addr(vec_addr_e), .resume(), .resume_pc(), .resume_x(), .resume_a(),
    .condition_flags(), .stop_latch(), .wait_latch(), .dir_a(), .dir_b(), .port_a_out(),
    .port_b_out(), .stack_addr(), .stack_we(), .stack_re(), .stack_wdata(), .stack_rdata,
    .s_awaddr, .s_awvalid, .s_awready(), .s_wdata, .s_wstrb, .s_wvalid, .s_wready(),
    .s_bresp(), .s_bvalid(), .s_bready, .s_araddr, .s_arvalid, .s_arready(), .s_rdata(),
    .s_rresp(), .s_rvalid(), .s_rready);
  ////////////////////////////////////////////////////////////////////////////////
  // stack ram with synchronous read; vector fetches counted
  always @(posedge clk) begin
    if (stack_we) mem[stack_addr] <= stack_wdata;
    stack_rdata <= mem[stack_addr];
    if (vec_fetch) vf_cnt <= vf_cnt + 1;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task pulse(input logic [2:0] k);
    ev <= k;
    @(posedge clk);
    ev <= 3'h0;
  endtask : pulse
  task wvec(input logic [10:0] e);
    int n;
    n = vf_cnt;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (vf_cnt != n) break;
    end
    chk("fetch", vf_cnt - n, 1);
    chk("vector", vec_addr, e);
    @(posedge clk);
  endtask : wvec
  task wres;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (resume === 1'h1) break;
    end
    chk("resume", {resume, resume_pc, resume_x, resume_a}, {1'h1, cpu_pc, cpu_x, cpu_a});
    // flags are restored at the edge that ends the resume cycle
    @(posedge clk);
    #1;
    chk("flags", condition_flags, 5'h00);
    @(posedge clk);
  endtask : wres
  ////////////////////////////////////////////////////////////////////////////////
  // an idle edge after each transfer keeps ready lowering and raising apart
  task axw(input logic [7:0] ad, input logic [31:0] d);
    s_awaddr <= ad;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (s_bvalid !== 1'h1);
    rs = s_bresp;
    s_bready <= 1'h0;
    @(posedge clk);
  endtask : axw
  task axr(input logic [7:0] ad);
    s_araddr <= ad;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'h0;
    end while (s_rvalid !== 1'h1);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'h0;
    @(posedge clk);
  endtask : axr
  task stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    rst_n <= 1'h1;
    osc_on <= 1'h1;
    cyc(40);
    chk("held", core_reset, 1'h1);
    rst_req <= 1'h0;
    wvec(ris_pkg::VEC_RESET);
    axw(ris_pkg::ADDR_DIR, 32'ha55a);
    axw(ris_pkg::ADDR_PORT, 32'h1234);
    irq_req <= 1'h1;
    cyc(6);
    pulse(3'h1);
    cyc(20);
    chk("masked", vf_cnt, 1);
    axw(ris_pkg::ADDR_FLAGS, 32'h0);
    axw(ris_pkg::ADDR_TIMER, 32'h0);
    timer_event <= 1'h1;
    cyc(1);
    timer_event <= 1'h0;
    cyc(2);
    pulse(3'h1);
    wvec(ris_pkg::VEC_EXT);
    for (int i = 0; i < 5; i++) begin
      chk("frame", mem[127 - i], i == 0 ? cpu_pc[7:0] : i == 1 ? {5'h00, cpu_pc[10:8]} :
        i == 2 ? cpu_x : i == 3 ? cpu_a : 8'h00);
    end
    chk("mask", condition_flags[ris_pkg::CC_I], 1'h1);
    pulse(3'h4);
    wres();
    pulse(3'h1);
    wvec(ris_pkg::VEC_EXT);
    chk("edge only", vec_addr_e, ris_pkg::VEC_TIMER);
    irq_req <= 1'h0;
    pulse(3'h4);
    wres();
    pulse(3'h1);
    wvec(ris_pkg::VEC_TIMER);
    pulse(3'h2);
    wvec(ris_pkg::VEC_SWI);
    axr(ris_pkg::ADDR_STATUS);
    chk("sp", rd[6:0], 7'h75);
    stop_enter <= 1'h1;
    wait_enter <= 1'h1;
    rst_req <= 1'h1;
    cyc(1);
    {stop_enter, wait_enter, rst_req} <= 3'h0;
    cyc(1);
    chk("latches", {stop_latch, wait_latch}, 2'h3);
    // stretched pin plus three-stage synchroniser
    cyc(5);
    chk("abort", core_reset, 1'h1);
    wvec(ris_pkg::VEC_RESET);
    axr(ris_pkg::ADDR_DIR);
    chk("dir", rd, 32'h0);
    axr(ris_pkg::ADDR_PORT);
    chk("port", rd, 32'h1234);
    axr(ris_pkg::ADDR_TIMER);
    chk("timer", rd[7:6], 2'h1);
    axr(ris_pkg::ADDR_FLAGS);
    chk("flags", rd, 32'h08);
    axr(ris_pkg::ADDR_STATUS);
    chk("status", rd[11:0], 12'h07f);
    axr(8'h40);
    chk("resp", rs, ris_pkg::RESP_SLVERR);
    osc_on <= 1'h0;
    cyc(8);
    osc_on <= 1'h1;
    cyc(8);
    chk("por", core_reset, 1'h1);
    wvec(ris_pkg::VEC_RESET);
    stop_test();
  end
  initial begin
    cyc(5000);
    mismatches++;
    stop_test();
  end
endmodule : reset_interrupt_sequencer_tb
